/* verilog/aic_regport.sv */
/*
  I2C target and register map of a four-channel amplifier controller.
  Assumes SCL and SDA are sampled on i_mclk; the bus is slow against it.
  Events and status come from the analog side on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

module aic_regport
  import aic_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Device pins
  input wire logic i_standby_n,
  input wire logic [1:0] i_addr_sel,
  // Serial bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Analog side
  input wire aic_latch_ev_t i_latch_ev,
  input wire aic_live_t i_live,
  output aic_ctrl_t o_ctrl,
  output logic [7:0] o_fault_sum
);

  logic rst_meta_q, rst_sync_q;
  logic [1:0] scl_sync_q, sda_sync_q, stby_sync_q;
  logic [1:0] asel_meta_q, asel_q;
  logic scl_d1_q, sda_d1_q;
  logic standby;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else if (i_ce) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      stby_sync_q <= 2'h3;
      asel_meta_q <= 2'h0;
      asel_q <= 2'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else if (i_ce) begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      stby_sync_q <= {stby_sync_q[0], i_standby_n};
      asel_meta_q <= i_addr_sel;
      asel_q <= asel_meta_q;
      scl_d1_q <= scl_sync_q[1];
      sda_d1_q <= sda_sync_q[1];
    end
  end

  wire scl = scl_sync_q[1];
  wire sda = sda_sync_q[1];
  assign standby = !stby_sync_q[1];
  wire scl_rise = scl && !scl_d1_q;
  wire scl_fall = !scl && scl_d1_q;
  wire bus_start = scl && scl_d1_q && sda_d1_q && !sda;
  wire bus_stop = scl && scl_d1_q && !sda_d1_q && sda;

  function automatic logic is_writable(input logic [7:0] off);
    is_writable = (off >= `AIC_OFF_GAIN && off <= `AIC_OFF_OUT_CTRL_B) ||
                  off == `AIC_OFF_DC_THRESH;
  endfunction

  aic_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] ptr_q;
  logic ptr_loaded_q;
  logic read_dir_q;
  logic ack_bit_q;
  logic [7:0] fault_sum_q, chan_prot_q, diag_a_q, diag_b_q;
  aic_ctrl_t ctrl_q;
  logic wr_stb;
  logic [7:0] rd_data;

  // Address byte test: fixed pattern then select bits
  // Byte is seven address bits then direction in bit 0
  wire addr_match = shift_q[7:3] == `AIC_ADDR_FIXED && shift_q[2:1] == asel_q;

  function automatic logic [7:0] read_mux(input logic [7:0] off);
    if (off == `AIC_OFF_FAULT_SUM) read_mux = fault_sum_q;
    else if (off == `AIC_OFF_CHAN_PROT) read_mux = chan_prot_q;
    else if (off == `AIC_OFF_DIAG_A) read_mux = diag_a_q;
    else if (off == `AIC_OFF_DIAG_B) read_mux = diag_b_q;
    else if (off == `AIC_OFF_TEMP_VOLT) read_mux = i_live.temp_volt;
    else if (off == `AIC_OFF_OUT_STATE) read_mux = i_live.out_state;
    else if (off == `AIC_OFF_PLAY_MUTE) read_mux = i_live.play_mute;
    else if (off == `AIC_OFF_DIAG_MODE) read_mux = i_live.diag_mode;
    else if (off == `AIC_OFF_GAIN) read_mux = ctrl_q.gain;
    else if (off == `AIC_OFF_OVERCUR) read_mux = ctrl_q.overcur;
    else if (off == `AIC_OFF_FREQ_CLIP) read_mux = ctrl_q.freq_clip;
    else if (off == `AIC_OFF_DIAG_OSC) read_mux = ctrl_q.diag_osc;
    else if (off == `AIC_OFF_OUT_CTRL_A) read_mux = ctrl_q.out_ctrl_a;
    else if (off == `AIC_OFF_OUT_CTRL_B) read_mux = ctrl_q.out_ctrl_b;
    else if (off == `AIC_OFF_DC_THRESH) read_mux = ctrl_q.dc_thresh;
    else if (off == `AIC_OFF_THERMAL) read_mux = i_live.thermal;
    else read_mux = `AIC_RST_BYTE;
  endfunction

  assign rd_data = read_mux(ptr_q);

  // Data byte completes on the eighth rising SCL edge of a write byte
  assign wr_stb = state_q == AIC_WRB && scl_rise && bit_cnt_q == 4'h7 && ptr_loaded_q;

  // Protocol engine
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= AIC_IDLE;
      shift_q <= `AIC_RST_BYTE;
      bit_cnt_q <= 4'h0;
      ptr_q <= `AIC_RST_BYTE;
      ptr_loaded_q <= 1'b0;
      read_dir_q <= 1'b0;
      ack_bit_q <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (i_ce) begin
      if (standby) begin
        state_q <= AIC_IDLE;
        ptr_q <= `AIC_RST_BYTE;
        ptr_loaded_q <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (bus_start) begin
        // Repeated start keeps the pointer for reads
        state_q <= AIC_ADDR;
        bit_cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_q <= AIC_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_q)
          AIC_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          AIC_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              if (addr_match) begin
                read_dir_q <= shift_q[0];
                ptr_loaded_q <= 1'b0;
                o_sda_out <= 1'b0;
                o_sda_oe <= 1'b1;
                ack_bit_q <= shift_q[0];
                state_q <= AIC_ACK;
              end else begin
                state_q <= AIC_IDLE;
              end
            end
          end
          AIC_ACK: begin
            // Release after the ninth clock; reads load the first bit
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (read_dir_q) begin
                shift_q <= {rd_data[6:0], 1'b0};
                o_sda_oe <= !rd_data[7];
                o_sda_out <= 1'b0;
                state_q <= AIC_RDB;
              end else begin
                o_sda_oe <= 1'b0;
                state_q <= AIC_WRB;
              end
            end
          end
          AIC_WRB: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              if (!ptr_loaded_q) begin
                ptr_q <= shift_q;
                ptr_loaded_q <= 1'b1;
              end
              o_sda_out <= 1'b0;
              o_sda_oe <= 1'b1;
              state_q <= AIC_ACK;
            end
          end
          AIC_RDB: begin
            // Open-drain: drive only zeros
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                o_sda_oe <= 1'b0;
                ptr_q <= ptr_q + 8'h01;
                state_q <= AIC_RACK;
              end else begin
                o_sda_oe <= !shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          AIC_RACK: begin
            if (scl_rise) begin
              ack_bit_q <= !sda;
            end else if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (ack_bit_q) begin
                shift_q <= {rd_data[6:0], 1'b0};
                o_sda_out <= 1'b0;
                o_sda_oe <= !rd_data[7];
                state_q <= AIC_RDB;
              end else begin
                state_q <= AIC_IDLE;
              end
            end
          end
          default: begin
            state_q <= AIC_IDLE;
          end
        endcase
        // Pointer steps after each data byte written, whether or not its offset is writable
        if (wr_stb) begin
          ptr_q <= ptr_q + 8'h01;
        end
      end
    end
  end

  // Control registers; only writable offsets change
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_q <= '0;
    end else if (i_ce) begin
      if (standby) begin
        ctrl_q <= '0;
      end else if (wr_stb && is_writable(ptr_q)) begin
        if (ptr_q == `AIC_OFF_GAIN) ctrl_q.gain <= {shift_q[6:0], sda};
        else if (ptr_q == `AIC_OFF_OVERCUR) ctrl_q.overcur <= {shift_q[6:0], sda};
        else if (ptr_q == `AIC_OFF_FREQ_CLIP) ctrl_q.freq_clip <= {shift_q[6:0], sda};
        else if (ptr_q == `AIC_OFF_DIAG_OSC) ctrl_q.diag_osc <= {shift_q[6:0], sda};
        else if (ptr_q == `AIC_OFF_OUT_CTRL_A) ctrl_q.out_ctrl_a <= {shift_q[6:0], sda};
        else if (ptr_q == `AIC_OFF_OUT_CTRL_B) ctrl_q.out_ctrl_b <= {shift_q[6:0], sda};
        else ctrl_q.dc_thresh <= {shift_q[6:0], sda};
      end
    end
  end

  // Latched faults: sticky until standby or reset; no software clear
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fault_sum_q <= `AIC_RST_BYTE;
      chan_prot_q <= `AIC_RST_BYTE;
      diag_a_q <= `AIC_RST_BYTE;
      diag_b_q <= `AIC_RST_BYTE;
    end else if (i_ce) begin
      if (standby) begin
        fault_sum_q <= `AIC_RST_BYTE;
        chan_prot_q <= `AIC_RST_BYTE;
        diag_a_q <= `AIC_RST_BYTE;
        diag_b_q <= `AIC_RST_BYTE;
      end else begin
        fault_sum_q <= fault_sum_q | i_latch_ev.fault_sum;
        chan_prot_q <= chan_prot_q | i_latch_ev.chan_prot;
        diag_a_q <= diag_a_q | i_latch_ev.diag_a;
        diag_b_q <= diag_b_q | i_latch_ev.diag_b;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      o_ctrl <= '0;
      o_fault_sum <= `AIC_RST_BYTE;
    end else if (i_ce) begin
      o_ctrl <= ctrl_q;
      o_fault_sum <= fault_sum_q;
    end
  end

endmodule

`default_nettype wire

/* common/aic_cfg.svh */
/*
  Constants for the amplifier register port: bus address pattern,
  register offsets, fault bit positions and reset values.
  Assumes inclusion by the design file and the port checker only.
*/
`ifndef AIC_CFG_SVH
`define AIC_CFG_SVH

`define AIC_ADDR_FIXED 5'h1b
`define AIC_OFF_FAULT_SUM 8'h00
`define AIC_OFF_CHAN_PROT 8'h01
`define AIC_OFF_DIAG_A 8'h02
`define AIC_OFF_DIAG_B 8'h03
`define AIC_OFF_TEMP_VOLT 8'h04
`define AIC_OFF_OUT_STATE 8'h05
`define AIC_OFF_PLAY_MUTE 8'h06
`define AIC_OFF_DIAG_MODE 8'h07
`define AIC_OFF_GAIN 8'h08
`define AIC_OFF_OVERCUR 8'h09
`define AIC_OFF_FREQ_CLIP 8'h0a
`define AIC_OFF_DIAG_OSC 8'h0b
`define AIC_OFF_OUT_CTRL_A 8'h0c
`define AIC_OFF_OUT_CTRL_B 8'h0d
`define AIC_OFF_DC_THRESH 8'h10
`define AIC_OFF_THERMAL 8'h13
`define AIC_BIT_OTW 0
`define AIC_BIT_DC_ANY 1
`define AIC_BIT_OC_ANY 2
`define AIC_BIT_OTSD 3
`define AIC_BIT_CP_UV 4
`define AIC_BIT_ANALOG_UV 5
`define AIC_BIT_PSTAGE_UV 6
`define AIC_BIT_PSTAGE_OV 7
`define AIC_RST_BYTE 8'h00
`define AIC_RST_OUT_STATE 8'h0f

`endif

/* common/aic_pkg.sv */
/*
  Types for the amplifier register port.
  Assumes aic_cfg.svh holds the numeric constants.
*/
`default_nettype none

package aic_pkg;
  typedef enum logic [5:0] {
    AIC_IDLE = 6'b000001,
    AIC_ADDR = 6'b000010,
    AIC_ACK = 6'b000100,
    AIC_WRB = 6'b001000,
    AIC_RDB = 6'b010000,
    AIC_RACK = 6'b100000
  } aic_state_t;

  // Event inputs from the analog side, one pulse or level per fault
  typedef struct packed {
    logic [7:0] fault_sum;
    logic [7:0] chan_prot;
    logic [7:0] diag_a;
    logic [7:0] diag_b;
  } aic_latch_ev_t;

  // Live status seen from the analog side
  typedef struct packed {
    logic [7:0] temp_volt;
    logic [7:0] out_state;
    logic [7:0] play_mute;
    logic [7:0] diag_mode;
    logic [7:0] thermal;
  } aic_live_t;

  // Control bytes driven to the analog side
  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] overcur;
    logic [7:0] freq_clip;
    logic [7:0] diag_osc;
    logic [7:0] out_ctrl_a;
    logic [7:0] out_ctrl_b;
    logic [7:0] dc_thresh;
  } aic_ctrl_t;
endpackage

`default_nettype wire

/* sim/aic_regport_sva.sv */
/*
  Port checker for the amplifier register port.
  Assumes the bus controller keeps SCL phases of at least 8 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aic_cfg.svh"

module aic_regport_sva
  import aic_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Pins and bus
  input wire logic i_standby_n,
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // Analog side
  input wire aic_latch_ev_t i_latch_ev,
  input wire aic_ctrl_t o_ctrl,
  input wire logic [7:0] o_fault_sum
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_oe_held;
    o_sda_oe [*8];
  endsequence
  sequence s_awake;
    i_standby_n [*6];
  endsequence
  property p_oe_rise_low;
    $rose(o_sda_oe) |-> !i_scl;
  endproperty
  property p_oe_hold;
    $rose(o_sda_oe) |-> s_oe_held;
  endproperty
  property p_oe_fall_low;
    $fell(o_sda_oe) |-> !i_scl;
  endproperty
  property p_oe_steady;
    i_scl [*4] |-> $stable(o_sda_oe);
  endproperty
  property p_out_zero;
    o_sda_oe |-> !o_sda_out;
  endproperty
  property p_ctrl_scl;
    $changed(o_ctrl) |-> i_scl && $past(i_scl, 2);
  endproperty
  property p_standby;
    !i_standby_n [*6] |-> !o_sda_oe && o_ctrl == '0 && o_fault_sum == 8'h00;
  endproperty
  property p_fault_otw;
    (s_awake ##0 i_latch_ev.fault_sum[`AIC_BIT_OTW]) |-> ##[1:4] o_fault_sum[`AIC_BIT_OTW];
  endproperty
  property p_fault_pov;
    (s_awake ##0 i_latch_ev.fault_sum[7]) |-> ##[1:4] o_fault_sum[7];
  endproperty
  property p_sticky;
    s_awake |=> (o_fault_sum & $past(o_fault_sum)) == $past(o_fault_sum);
  endproperty
  a_oe_rise_low: assert property (p_oe_rise_low) else $error("pull while scl high");
  a_oe_hold: assert property (p_oe_hold) else $error("pull too short");
  a_oe_fall_low: assert property (p_oe_fall_low) else $error("release while scl high");
  a_oe_steady: assert property (p_oe_steady) else $error("sda moved in scl high");
  a_out_zero: assert property (p_out_zero) else $error("sda driven high");
  a_ctrl_scl: assert property (p_ctrl_scl) else $error("control moved off bit");
  a_standby: assert property (p_standby) else $error("standby kept state");
  a_fault_otw: assert property (p_fault_otw) else $error("warning not latched");
  a_fault_pov: assert property (p_fault_pov) else $error("overvoltage not latched");
  a_sticky: assert property (p_sticky) else $error("fault bit cleared");
endmodule

bind aic_regport aic_regport_sva i_aic_regport_sva (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_standby_n(i_standby_n), .i_scl(i_scl),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_latch_ev(i_latch_ev),
  .o_ctrl(o_ctrl), .o_fault_sum(o_fault_sum)
);
`default_nettype wire

/* sim/aic_i2c_host.sv */
/*
  Behavioural bus controller that faces the register port.
  Assumes an open-drain SDA with pull-up built by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module aic_i2c_host #(
  parameter int PH = 8
) (
  // Clock
  input wire logic i_mclk,
  // Bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe,
  // One result per byte
  output logic [7:0] o_res,
  output logic o_res_stb
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_res = 8'h00;
    o_res_stb = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Also a repeated START when SCL is low
  task automatic start();
    o_sda_oe = 1'b0;
    tick(PH);
    o_scl = 1'b1;
    tick(PH);
    o_sda_oe = 1'b1;
    tick(PH);
    o_scl = 1'b0;
    tick(PH);
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    tick(PH);
    o_scl = 1'b1;
    tick(PH);
    o_sda_oe = 1'b0;
    tick(PH);
  endtask
  task automatic bit_x(input logic v, output logic r);
    o_sda_oe = ~v;
    tick(PH);
    o_scl = 1'b1;
    tick(PH / 2);
    r = i_sda;
    tick(PH / 2);
    o_scl = 1'b0;
    tick(1);
  endtask
  task automatic post(input logic [7:0] v);
    o_res = v;
    o_res_stb = 1'b1;
    tick(1);
    o_res_stb = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    post({7'h00, r});
  endtask
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, r);
    post(d);
  endtask
endmodule
`default_nettype wire

/* sim/test_aic_regport.sv */
/*
  Self-checking bench for the amplifier register port.
  Assumes the controller model and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module test_aic_regport;
  import aic_pkg::*;
  localparam int MAX_CYC = 80000;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_standby_n = 1'b1;
  logic ce = 1'b1;
  logic [1:0] sel = 2'b00;
  aic_latch_ev_t ev = '0;
  aic_live_t live = '0;
  aic_ctrl_t ctrl;
  logic [7:0] fsum;
  logic d_out, d_oe, h_scl, h_oe, r_stb;
  logic [7:0] r_val;
  logic [7:0] dw = 8'hd8;
  logic [7:0] exp_q[$];
  logic [7:0] m[0:19];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  wire logic sda;
  // Open drain with pull-up
  assign sda = ~((d_oe & ~d_out) | h_oe);
  aic_regport i_aic_regport (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce), .i_standby_n(i_standby_n),
    .i_addr_sel(sel), .i_scl(h_scl), .i_sda(sda), .o_sda_out(d_out), .o_sda_oe(d_oe),
    .i_latch_ev(ev), .i_live(live), .o_ctrl(ctrl), .o_fault_sum(fsum)
  );
  aic_i2c_host i_aic_i2c_host (
    .i_mclk(i_mclk), .i_sda(sda), .o_scl(h_scl), .o_sda_oe(h_oe), .o_res(r_val),
    .o_res_stb(r_stb)
  );
  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      err_count++;
      complete_run();
    end
  end
  always @(posedge i_mclk) begin
    if (r_stb === 1'b1) begin
      check("bus byte", r_val, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
  end
  function automatic logic rw(input int a);
    return (a >= 8 && a <= 13) || a == 16;
  endfunction
  task automatic wb(input logic [7:0] b, input logic [7:0] e);
    exp_q.push_back(e);
    i_aic_i2c_host.wbyte(b);
  endtask
  task automatic point(input logic [7:0] off);
    i_aic_i2c_host.start();
    wb(dw, 8'h00);
    wb(off, 8'h00);
  endtask
  task automatic wr_burst(input logic [7:0] off, input int n);
    logic [7:0] v;
    point(off);
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      wb(v, 8'h00);
      if (rw(off + i)) m[off + i] = v;
    end
    i_aic_i2c_host.stop();
    repeat (8) @(negedge i_mclk);
    check("control", ctrl, {m[8], m[9], m[10], m[11], m[12], m[13], m[16]});
  endtask
  task automatic rd_burst(input logic [7:0] off, input int n);
    point(off);
    i_aic_i2c_host.start();
    wb(dw | 8'h01, 8'h00);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(m[off + i]);
      i_aic_i2c_host.rbyte(i == n - 1);
    end
    i_aic_i2c_host.stop();
  endtask
  task automatic pulse_ev();
    aic_latch_ev_t v;
    v = $urandom;
    ev = v;
    @(negedge i_mclk);
    ev = '0;
    {m[0], m[1], m[2], m[3]} = {m[0], m[1], m[2], m[3]} | v;
  endtask
  initial begin
    void'($urandom(4617));
    foreach (m[i]) m[i] = 8'h00;
    repeat (6) @(negedge i_mclk);
    i_resetn = 1'b1;
    repeat (8) @(negedge i_mclk);
    for (int k = 0; k < 4; k++) begin
      sel = 2'(k);
      dw = {5'b11011, sel, 1'b0};
      repeat (8) @(negedge i_mclk);
      i_aic_i2c_host.start();
      wb(dw ^ (k[0] ? 8'h80 : 8'h02), 8'h01);
      wb(8'h08, 8'h01);
      i_aic_i2c_host.stop();
      wr_burst(8'h08, 6);
      rd_burst(8'h08, 6);
    end
    wr_burst(8'h0b, 1);
    wr_burst(8'h0e, 3);
    wr_burst(8'h00, 2);
    pulse_ev();
    pulse_ev();
    live = {$urandom, 8'($urandom)};
    {m[4], m[5], m[6], m[7], m[19]} = live;
    rd_burst(8'h00, 20);
    check("fault copy", fsum, m[0]);
    // Frozen enable: a short standby pulse must not reach the synchroniser
    ce = 1'b0;
    i_standby_n = 1'b0;
    repeat (3) @(negedge i_mclk);
    i_standby_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    ce = 1'b1;
    repeat (4) @(negedge i_mclk);
    check("frozen control", ctrl, {m[8], m[9], m[10], m[11], m[12], m[13], m[16]});
    check("frozen faults", fsum, m[0]);
    i_standby_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    check("standby control", ctrl, 64'h0);
    check("standby faults", fsum, 8'h00);
    i_standby_n = 1'b1;
    foreach (m[i]) if (i < 4 || rw(i)) m[i] = 8'h00;
    repeat (8) @(negedge i_mclk);
    rd_burst(8'h00, 20);
    rd_burst(8'h13, 1);
    complete_run();
  end
endmodule
`default_nettype wire
